// ---- logic/sfr_cfg.svh ----
// opcodes, field limits and timing counts of the serial flash read path
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH

`define SFR_OPC_CONT_FAST 8'h0B
`define SFR_OPC_CONT_SLOW 8'h03
`define SFR_OPC_CONT_LOWPWR 8'h01
`define SFR_OPC_PAGE 8'hD2
`define SFR_OPC_BUF1_FAST 8'hD4
`define SFR_OPC_BUF1_SLOW 8'hD1
`define SFR_OPC_BUF2_FAST 8'hD6
`define SFR_OPC_BUF2_SLOW 8'hD3

`define SFR_DUMMY_NONE 3'h0
`define SFR_DUMMY_ONE 3'h1
`define SFR_DUMMY_PAGE 3'h4

`define SFR_OPC_LAST_BIT 5'h07
`define SFR_ADDR_LAST_BIT 5'h17
`define SFR_BIT_LAST 3'h7

`define SFR_LAST_BYTE_528 10'h20F
`define SFR_LAST_BYTE_512 10'h1FF
`define SFR_LAST_ROW 12'hFFF

`define SFR_SCK_HALF_LAST 3'h3
`define SFR_CS_IDLE_LAST 3'h3

`endif

// ---- logic/sfr_pkg.sv ----
// types and shared opcode decoding for the serial flash read path
`include "sfr_cfg.svh"

package sfr_pkg;

  typedef enum logic [2:0] {
    SFR_OP_NONE,
    SFR_OP_CONT,
    SFR_OP_PAGE,
    SFR_OP_BUF1,
    SFR_OP_BUF2
  } sfr_read_kind_type;

  typedef enum logic [2:0] {
    SFR_PH_OPCODE,
    SFR_PH_ADDR,
    SFR_PH_DUMMY,
    SFR_PH_DATA,
    SFR_PH_IGNORE
  } sfr_phase_type;

  typedef enum logic [1:0] {
    SFR_HS_IDLE,
    SFR_HS_SHIFT,
    SFR_HS_DESELECT
  } sfr_host_state_type;

  function automatic sfr_read_kind_type sfr_kind_of(input logic [7:0] opc);
    sfr_read_kind_type k;
    k = SFR_OP_NONE;
    if (opc == `SFR_OPC_CONT_FAST || opc == `SFR_OPC_CONT_SLOW || opc == `SFR_OPC_CONT_LOWPWR) begin
      k = SFR_OP_CONT;
    end else if (opc == `SFR_OPC_PAGE) begin
      k = SFR_OP_PAGE;
    end else if (opc == `SFR_OPC_BUF1_FAST || opc == `SFR_OPC_BUF1_SLOW) begin
      k = SFR_OP_BUF1;
    end else if (opc == `SFR_OPC_BUF2_FAST || opc == `SFR_OPC_BUF2_SLOW) begin
      k = SFR_OP_BUF2;
    end
    return k;
  endfunction

  function automatic logic [2:0] sfr_dummy_bytes(input logic [7:0] opc);
    logic [2:0] d;
    d = `SFR_DUMMY_NONE;
    if (opc == `SFR_OPC_CONT_FAST || opc == `SFR_OPC_BUF1_FAST || opc == `SFR_OPC_BUF2_FAST) begin
      d = `SFR_DUMMY_ONE;
    end else if (opc == `SFR_OPC_PAGE) begin
      d = `SFR_DUMMY_PAGE;
    end
    return d;
  endfunction

  typedef struct packed {
    sfr_phase_type phase;
    sfr_read_kind_type kind;
    logic [4:0] cnt;
    logic [2:0] dummy;
    logic [23:0] sh;
    logic [11:0] row;
    logic [9:0] col;
    logic [9:0] arr_col;
    logic [9:0] buf_col;
    logic [2:0] bitn;
    logic sz512;
    logic from_buffer;
    logic buffer2;
    logic active;
  } sfr_dev_state_type;

  typedef struct packed {
    sfr_host_state_type state;
    logic [2:0] div;
    logic sck;
    logic cs_n;
    logic si;
    logic [63:0] tx;
    logic [6:0] hdr_left;
    logic [18:0] data_left;
    logic [7:0] rx;
    logic [2:0] rx_bits;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
    logic ready;
  } sfr_host_state_type_reg_type;

endpackage

// ---- logic/sfr_link_if.sv ----
// serial link between the flash read host and the flash device
`timescale 1ns/100ps

interface sfr_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  wire so_line;

  // released serial output reads high, as if pulled up
  assign so_line = so_oe ? so : 1'b1;

  modport host (
    output cs_n,
    output sck,
    output si,
    input so_line
  );

  modport device (
    input cs_n,
    input sck,
    input si,
    output so,
    output so_oe
  );
endinterface

// ---- logic/sfr_sync2.sv ----
// two flip-flop level synchroniser
`timescale 1ns/100ps

module sfr_sync2 (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // level
  input wire logic d_in,
  output logic q_out
);
  logic meta;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule

// ---- logic/sfr_device.sv ----
// flash device end: decodes read opcodes and streams array or buffer data
`timescale 1ns/100ps
`include "sfr_cfg.svh"

// Overview of operation
// - 0Bh: opcode, address, one dummy, data
// - 528 pages: 12-bit row, 10-bit column
// - 512 pages: 21-bit address, 9-bit column
// - page end continues into next page
// - array end wraps to first page
// - chip select rise ends read, releases output
// - host holds select low whole transaction
// - 03h: opcode, address, then data
// - 01h: no dummy, continuous behaviour
// - array reads never touch the buffers
// - D2h: address plus four dummy bytes
// - page read wraps within same page
// - D4h/D1h buffer one, D6h/D3h buffer two
// - 528 buffer: 14 don't-care, 10-bit offset
// - 512 buffer: 15 don't-care, 9-bit offset
// - fast buffer opcodes need one dummy
// - buffer read wraps to buffer start
// - slow opcodes only at low rates
// - everything shifted most significant bit first
module sfr_device
  import sfr_pkg::*;
(
  // serial link, clocked by its own clock
  sfr_link_if.device link,
  // reset and configuration
  input wire logic reset_in,
  input wire logic page_size_512_in,
  // main array read port, combinational read
  output logic [11:0] row_index_bits_out,
  output logic [9:0] byte_offset_bits_out,
  input wire logic [7:0] array_data_in,
  // buffer read port, combinational read
  output logic buffer_sel_out,
  output logic [9:0] buffer_offset_bits_out,
  input wire logic [7:0] buffer_data_in,
  // status
  output logic read_active_out
);

  sfr_dev_state_type q;
  sfr_dev_state_type next_q;
  logic size512;
  logic [23:0] addr_word;
  logic [7:0] opc_word;
  logic [7:0] data_byte;
  logic so_bit;
  logic so_en;
  logic data_bit;
  logic reset_sync;
  sfr_read_kind_type opc_kind;

  // reset arrives from the host clock domain and only acts while the link clock runs
  sfr_sync2 u_reset_sync (
    .clk_in(link.sck),
    .reset_in(1'b0),
    .d_in(reset_in),
    .q_out(reset_sync)
  );

  // page size pin comes from outside the link domain
  sfr_sync2 u_size_sync (
    .clk_in(link.sck),
    .reset_in(reset_sync),
    .d_in(page_size_512_in),
    .q_out(size512)
  );

  function automatic logic [9:0] last_col(input logic sz512);
    return sz512 ? `SFR_LAST_BYTE_512 : `SFR_LAST_BYTE_528;
  endfunction

  // last bit index of the dummy phase; four dummy bytes use the whole 5-bit counter
  function automatic logic [4:0] dummy_last(input logic [2:0] n);
    logic [5:0] bits;
    bits = {n, 3'h0} - 6'h01;
    return bits[4:0];
  endfunction

  assign opc_word = {q.sh[6:0], link.si};
  assign addr_word = {q.sh[22:0], link.si};
  // decoded once so kind and phase always agree
  assign opc_kind = sfr_kind_of(opc_word);

  // header bits shift in on every rise; the phase decides what they mean
  always_comb begin
    next_q = q;
    next_q.sh = {q.sh[22:0], link.si};
    next_q.cnt = q.cnt + 5'h01;
    unique case (q.phase)
      SFR_PH_OPCODE: begin
        // opcode bit 7 arrives on the first rise after select
        if (q.cnt == `SFR_OPC_LAST_BIT) begin
          next_q.cnt = 5'h00;
          next_q.kind = opc_kind;
          next_q.dummy = sfr_dummy_bytes(opc_word);
          next_q.phase = (opc_kind == SFR_OP_NONE) ? SFR_PH_IGNORE : SFR_PH_ADDR;
        end
      end
      SFR_PH_ADDR: begin
        if (q.cnt == `SFR_ADDR_LAST_BIT) begin
          next_q.cnt = 5'h00;
          next_q.sz512 = size512;
          next_q.from_buffer = (q.kind == SFR_OP_BUF1) || (q.kind == SFR_OP_BUF2);
          next_q.buffer2 = (q.kind == SFR_OP_BUF2);
          if (next_q.from_buffer) begin
            // leading bits are don't-care for buffer offsets
            next_q.row = 12'h000;
            next_q.col = size512 ? {1'b0, addr_word[8:0]} : addr_word[9:0];
          end else if (size512) begin
            next_q.row = addr_word[20:9];
            next_q.col = {1'b0, addr_word[8:0]};
          end else begin
            next_q.row = addr_word[21:10];
            next_q.col = addr_word[9:0];
          end
          next_q.bitn = 3'h0;
          if (q.dummy == `SFR_DUMMY_NONE) begin
            next_q.phase = SFR_PH_DATA;
            next_q.active = 1'b1;
          end else begin
            next_q.phase = SFR_PH_DUMMY;
          end
        end
      end
      SFR_PH_DUMMY: begin
        // dummy bits are clocked in and discarded
        if (q.cnt == dummy_last(q.dummy)) begin
          next_q.cnt = 5'h00;
          next_q.phase = SFR_PH_DATA;
          next_q.active = 1'b1;
        end
      end
      SFR_PH_DATA: begin
        // column steps after the eighth bit of each byte
        next_q.cnt = 5'h00;
        next_q.bitn = q.bitn + 3'h1;
        if (q.bitn == `SFR_BIT_LAST) begin
          if (q.col >= last_col(q.sz512)) begin
            next_q.col = 10'h000;
            if (q.kind == SFR_OP_CONT) begin
              // no gap cycle at page or array boundary
              next_q.row = (q.row == `SFR_LAST_ROW) ? 12'h000 : q.row + 12'h001;
            end
          end else begin
            next_q.col = q.col + 10'h001;
          end
        end
      end
      SFR_PH_IGNORE: begin
        // unsupported opcode: stay silent until deselect
        next_q.cnt = 5'h00;
      end
      default: begin
        next_q.phase = SFR_PH_IGNORE;
      end
    endcase
    // memory port addresses are registered so those outputs come straight from flops
    next_q.arr_col = next_q.from_buffer ? 10'h000 : next_q.col;
    next_q.buf_col = next_q.from_buffer ? next_q.col : 10'h000;
  end

  // chip select high clears the frame at once, since the link clock may stop
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      q <= sfr_dev_state_type'('0);
    end else if (reset_sync) begin
      q <= sfr_dev_state_type'('0);
    end else begin
      q <= next_q;
    end
  end

  // array and buffer are separate read ports, nothing here writes a buffer
  assign data_byte = q.from_buffer ? buffer_data_in : array_data_in;

  // bits leave most significant first
  assign data_bit = data_byte[`SFR_BIT_LAST - q.bitn];

  // output changes on the falling edge so the host samples a stable bit
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      so_bit <= 1'b0;
      so_en <= 1'b0;
    end else if (reset_sync) begin
      so_bit <= 1'b0;
      so_en <= 1'b0;
    end else begin
      so_bit <= data_bit;
      so_en <= (q.phase == SFR_PH_DATA);
    end
  end

  assign link.so = so_bit;
  assign link.so_oe = so_en;
  // memory reads must settle within half a link clock of these addresses moving
  assign row_index_bits_out = q.row;
  assign byte_offset_bits_out = q.arr_col;
  assign buffer_offset_bits_out = q.buf_col;
  assign buffer_sel_out = q.buffer2;
  assign read_active_out = q.active;

endmodule

// ---- logic/sfr_host.sv ----
// host end: issues one read command per request and returns the data bytes
`timescale 1ns/100ps
`include "sfr_cfg.svh"

module sfr_host
  import sfr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // command request
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_opcode_in,
  input wire logic [23:0] cmd_addr_in,
  input wire logic [15:0] cmd_len_in,
  output logic cmd_ready_out,
  // read data
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic done_out,
  // serial link, host makes the link clock
  sfr_link_if.host link
);

  sfr_host_state_type_reg_type q;
  sfr_host_state_type_reg_type next_q;
  logic so_sync;

  sfr_sync2 u_so_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .d_in(link.so_line),
    .q_out(so_sync)
  );

  always_comb begin
    next_q = q;
    next_q.rd_valid = 1'b0;
    next_q.done = 1'b0;
    unique case (q.state)
      SFR_HS_IDLE: begin
        next_q.sck = 1'b0;
        next_q.cs_n = 1'b1;
        next_q.div = 3'h0;
        if (cmd_valid_in) begin
          // header leaves most significant bit first, dummy bits are zero
          next_q.tx = {cmd_opcode_in, cmd_addr_in, 32'h0000_0000};
          next_q.hdr_left = 7'h20 + {1'b0, sfr_dummy_bytes(cmd_opcode_in), 3'h0};
          next_q.data_left = {cmd_len_in, 3'h0};
          next_q.rx_bits = 3'h0;
          next_q.si = cmd_opcode_in[7];
          next_q.cs_n = 1'b0;
          next_q.state = SFR_HS_SHIFT;
        end
      end
      SFR_HS_SHIFT: begin
        next_q.div = q.div + 3'h1;
        if (q.div == `SFR_SCK_HALF_LAST) begin
          next_q.div = 3'h0;
          next_q.sck = ~q.sck;
          if (!q.sck) begin
            // rising edge: device samples si, host takes the synced output bit
            if (q.hdr_left != 7'h00) begin
              next_q.hdr_left = q.hdr_left - 7'h01;
              next_q.tx = {q.tx[62:0], 1'b0};
            end else begin
              next_q.data_left = q.data_left - 19'h00001;
              next_q.rx = {q.rx[6:0], so_sync};
              next_q.rx_bits = q.rx_bits + 3'h1;
              if (q.rx_bits == `SFR_BIT_LAST) begin
                next_q.rd_data = {q.rx[6:0], so_sync};
                next_q.rd_valid = 1'b1;
              end
            end
          end else begin
            // falling edge: present next bit or end the frame
            next_q.si = (q.hdr_left != 7'h00) ? q.tx[63] : 1'b0;
            if (q.hdr_left == 7'h00 && q.data_left == 19'h00000) begin
              next_q.cs_n = 1'b1;
              next_q.state = SFR_HS_DESELECT;
            end
          end
        end
      end
      SFR_HS_DESELECT: begin
        // hold select high a while so the device sees a clean frame end
        next_q.div = q.div + 3'h1;
        if (q.div == `SFR_CS_IDLE_LAST) begin
          next_q.div = 3'h0;
          next_q.done = 1'b1;
          next_q.state = SFR_HS_IDLE;
        end
      end
      default: begin
        next_q.state = SFR_HS_IDLE;
      end
    endcase
    next_q.ready = (next_q.state == SFR_HS_IDLE) && !(q.state == SFR_HS_IDLE && cmd_valid_in);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q <= '{state: SFR_HS_IDLE, cs_n: 1'b1, default: '0};
    end else begin
      q <= next_q;
    end
  end

  assign cmd_ready_out = q.ready;
  assign rd_data_out = q.rd_data;
  assign rd_valid_out = q.rd_valid;
  assign done_out = q.done;
  assign link.cs_n = q.cs_n;
  assign link.sck = q.sck;
  assign link.si = q.si;

endmodule

// ---- sim/sfr_link_properties.sv ----
// concurrent checks on the serial link between the read host and the flash device
`timescale 1ns/100ps

module sfr_link_properties (
  // host clock domain
  input wire logic clk_in,
  input wire logic reset_in,
  // link signals
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic sck_d;
  logic [15:0] nrise;
  logic [7:0] op;
  logic [6:0] hdr;
  logic op_ok;

  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // rises counted per frame so the header length can be tied to the opcode
  always_ff @(posedge clk_in) begin
    sck_d <= sck;
    if (reset_in || cs_n) begin
      nrise <= 16'h0;
    end else if (sck && !sck_d) begin
      nrise <= nrise + 16'h1;
      if (nrise < 16'h8) begin
        op <= {op[6:0], si};
      end
    end
  end

  assign op_ok = op inside {8'h0B, 8'h03, 8'h01, 8'hD2, 8'hD4, 8'hD1, 8'hD6, 8'hD3};
  assign hdr = (op == 8'h0B || op == 8'hD4 || op == 8'hD6) ? 7'h28 : (op == 8'hD2) ? 7'h40 : 7'h20;

  sequence s_lead;
    (!sck) [*2] ##[1:6] $rose(sck);
  endsequence

  sequence s_high;
    sck [*4] ##1 !sck;
  endsequence

  AST_OE_ONLY_SELECTED: assert property (cs_n |-> !so_oe)
    else $error("serial output driven while deselected");
  AST_OE_UNTIL_DESELECT: assert property ($fell(so_oe) |-> cs_n)
    else $error("serial output released inside a frame");
  AST_SCK_IDLE_LOW: assert property (cs_n |-> !sck)
    else $error("link clock high while deselected");
  AST_FRAME_LEAD: assert property ($fell(cs_n) |-> s_lead)
    else $error("frame start without link clock");
  AST_SCK_HALF_PERIOD: assert property ($rose(sck) |-> s_high)
    else $error("link clock high phase wrong");
  AST_SI_STABLE_AT_RISE: assert property ($rose(sck) |-> $stable(si))
    else $error("serial input moved at a rising edge");
  AST_SO_MOVES_ON_FALL: assert property (so_oe && $past(so_oe) && !$stable(so) |-> $fell(sck))
    else $error("serial output moved off a falling edge");
  AST_HEADER_LENGTH: assert property ($fell(sck) && !cs_n && nrise == {9'h0, hdr} |-> so_oe == op_ok)
    else $error("data phase missing or unknown opcode answered");
  AST_OE_STARTS_AT_HEADER: assert property ($rose(so_oe) |-> $fell(sck) && nrise == {9'h0, hdr})
    else $error("serial output enabled at the wrong bit");
  AST_DESELECT_HOLD: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("deselect time too short");
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench: read host and flash device joined over the serial link
`timescale 1ns/100ps

module tb_top;
  logic clk_in = 1'b0;
  logic reset_in, valid, s512, rd_valid, done, ready, bsel, act;
  logic [7:0] op, rd_data, arr_d, buf_d;
  logic [23:0] addr, ra;
  logic [15:0] len;
  logic [11:0] row;
  logic [9:0] col, boff;
  logic [31:0] rnd = 32'h989CDAF2;
  int n_mismatch = 0;
  int n_tests = 0;
  int idx = 0;
  int cyc = 0;
  int psz;
  logic [7:0] ops [8] = '{8'h0B, 8'h03, 8'h01, 8'hD2, 8'hD4, 8'hD1, 8'hD6, 8'hD3};

  sfr_link_if link();
  sfr_host i_sfr_host (.clk_in(clk_in), .reset_in(reset_in), .cmd_valid_in(valid), .cmd_opcode_in(op),
    .cmd_addr_in(addr), .cmd_len_in(len), .cmd_ready_out(ready), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .done_out(done), .link(link));
  sfr_device i_sfr_device (.link(link), .reset_in(reset_in), .page_size_512_in(s512), .row_index_bits_out(row),
    .byte_offset_bits_out(col), .array_data_in(arr_d), .buffer_sel_out(bsel), .buffer_offset_bits_out(boff),
    .buffer_data_in(buf_d), .read_active_out(act));
  sfr_link_properties chk (.clk_in(clk_in), .reset_in(reset_in), .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
    .so(link.so), .so_oe(link.so_oe));

  always #12.5 clk_in = ~clk_in;

  // array and buffers get different patterns so a wrong source shows up
  function automatic logic [7:0] arr_byte(input logic [11:0] r, input logic [9:0] c);
    return r[7:0] ^ c[7:0] ^ {r[11:8], c[9:8], 2'h2};
  endfunction

  function automatic logic [7:0] buf_byte(input logic s, input logic [9:0] c);
    return ~c[7:0] ^ {s, c[9:8], 5'h13};
  endfunction

  assign arr_d = arr_byte(row, col);
  assign buf_d = buf_byte(bsel, boff);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic logic [23:0] mk(input logic [11:0] r, input int c);
    // high bits set on purpose: they must be ignored
    return s512 ? {3'h5, r, c[8:0]} : {2'h3, r, c[9:0]};
  endfunction

  function automatic logic [7:0] exp_byte(input logic [7:0] o, input logic [23:0] a, input int i);
    int sz, r, c;
    sz = s512 ? 512 : 528;
    r = s512 ? a[20:9] : a[21:10];
    c = (s512 ? a[8:0] : a[9:0]) + i;
    // opcode bit 1 picks the second buffer
    if (o inside {8'hD4, 8'hD1, 8'hD6, 8'hD3}) return buf_byte(o[1], 10'(c % sz));
    if (o != 8'hD2) r = (r + c / sz) % 4096;
    return arr_byte(12'(r), 10'(c % sz));
  endfunction

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task run(input logic [7:0] o, input logic [23:0] a, input logic [15:0] n);
    @(negedge clk_in);
    while (ready !== 1'b1) @(negedge clk_in);
    idx = 0;
    @(posedge clk_in);
    valid <= 1'b1;
    op <= o;
    addr <= a;
    len <= n;
    @(posedge clk_in);
    valid <= 1'b0;
    do @(negedge clk_in); while (done !== 1'b1);
    check("byte count", idx, n);
    check("released output", link.so_oe, 1'b0);
    check("released line", link.so_line, 1'b1);
    check("read active after frame", act, 1'b0);
    $display("test opcode %h address %h length %0d done", o, a, n);
  endtask

  // sampled on the falling clock so the registered data has settled
  always @(negedge clk_in) begin
    if (rd_valid === 1'b1) begin
      if (op inside {ops}) begin
        check("read byte", rd_data, exp_byte(op, addr, idx));
        check("read active", act, 1'b1);
      end else begin
        // refused opcode: the released line reads high
        check("refused byte", rd_data, 8'hFF);
        check("refused active", act, 1'b0);
      end
      if (!(op inside {8'hD4, 8'hD1, 8'hD6, 8'hD3})) check("buffer port idle", boff, 10'h000);
      idx++;
    end
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    reset_in = 1'b1;
    valid = 1'b0;
    op = 8'h00;
    addr = 24'h000000;
    len = 16'h0000;
    s512 = 1'b0;
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_in);
      s512 <= s[0];
      @(posedge clk_in);
      psz = s ? 512 : 528;
      run(8'h0B, mk(12'h005, psz - 1), 16'h0003);
      run(8'h03, mk(12'hFFF, psz - 1), 16'h0003);
      run(8'hD2, mk(12'h07A, psz - 2), 16'h0004);
      run(8'hD6, mk(12'hABC, psz - 1), 16'h0003);
      run(8'hD1, mk(12'h123, 0), 16'h0002);
      run(8'h01, mk(12'h000, 0), 16'h0000);
      run(8'h55, mk(12'h001, 3), 16'h0002);
      for (int k = 0; k < 8; k++) begin
        rnd = xs(rnd);
        ra = rnd[23:0];
        if (!s512 && ra[9:0] > 10'h20F) ra[9] = 1'b0;
        run(ops[k], ra, {13'h0000, rnd[26:24]} + 16'h0001);
      end
    end
    give_verdict();
  end
endmodule
